// >>> inc/sbst_pkg.sv
/*
  sbst_pkg: constants and types for the memory boundary-scan test port.
  assumes: one system clock samples the test pins; no software registers.
*/
package sbst_pkg;
  localparam int          IR_W        = 3;
  localparam int          ID_W        = 32;
  localparam int          BSC_WIDE    = 70;
  localparam int          BSC_NARROW  = 51;
  localparam int          BSC_MAX     = 70;
  localparam logic [2:0]  IR_FLOAT_A  = 3'h0;
  localparam logic [2:0]  IR_IDENT    = 3'h1;
  localparam logic [2:0]  IR_FLOAT_B  = 3'h2;
  localparam logic [2:0]  IR_SAMPLE   = 3'h4;
  localparam logic [2:0]  IR_CAP      = 3'h1;
  localparam int          ID_REV_LSB  = 28;
  localparam int          ID_CFG_LSB  = 18;
  localparam int          ID_VND_LSB  = 12;
  localparam int          ID_MFR_LSB  = 1;
  // arbitrary identity values, not those of any part
  localparam logic [3:0]  ID_REV      = 4'h1;
  localparam logic [9:0]  ID_CFG_WIDE = 10'h2A5;
  localparam logic [9:0]  ID_CFG_NARR = 10'h15A;
  localparam logic [5:0]  ID_VND      = 6'h2D;
  localparam logic [10:0] ID_MFR      = 11'h3C5;
  // unconnected places sit at these cell numbers (one-based from serial out)
  localparam int          NC_WIDE_A   = 34;
  localparam int          NC_WIDE_B   = 37;
  localparam int          NC_NARR_A   = 24;
  localparam int          NC_NARR_B   = 27;
  localparam int          TDO_MAX_NS  = 10;
  localparam int          CLK_NS      = 50;
  localparam int          TDO_CYC     = (TDO_MAX_NS / CLK_NS) < 1 ? 1 :
                                        (TDO_MAX_NS / CLK_NS);

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAUSE_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
    ST_EX1_IR, ST_PAUSE_IR, ST_EX2_IR, ST_UPD_IR
  } sbst_state_t;

  typedef struct packed {
    logic mode_sel;
    logic ser_in;
  } sbst_pins_t;
endpackage : sbst_pkg

// >>> core/sbst_sync.sv
/*
  sbst_sync: two-flop synchroniser for the test pins plus test clock edges.
  assumes: inputs are asynchronous to i_clk; undriven pins arrive as 1.
*/
`timescale 1ns/10ps
`default_nettype none
module sbst_sync #(
  parameter int W = 3
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync,
  output logic      [W-1:0] o_prev
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;
  logic [W-1:0] prev_reg;
  logic [W-1:0] prev_next;

  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  // zero reset: test clock parks low, so no false edge after reset
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign o_sync = sync_reg;
  assign o_prev = prev_reg;
endmodule // sbst_sync
`default_nettype wire

// >>> core/sbst_tap.sv
/*
  sbst_tap: boundary-scan test port of a pipelined memory, device side.
  assumes: test clock sampled by i_clk (20 MHz), test clock far slower;
  i_pad carries the pad levels that the boundary cells observe.
*/
`timescale 1ns/10ps
`default_nettype none
module sbst_tap #(
  parameter bit WIDE = 1'b1,
  parameter int NCELL = WIDE ? sbst_pkg::BSC_WIDE : sbst_pkg::BSC_NARROW
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_srst,
  input  wire logic                         i_tck,
  input  wire sbst_pkg::sbst_pins_t         i_pins,
  input  wire logic [sbst_pkg::BSC_MAX-1:0] i_pad,
  output logic                              o_tdo,
  output logic                              o_tdo_oe,
  output logic                              o_data_float
);
  logic [2:0] s_sync;
  logic [2:0] s_prev;
  logic       tck_rise;
  logic       tck_fall;
  logic [sbst_pkg::BSC_MAX-1:0] pad_sync;

  // undriven pins are pulled to 1 at the pad
  sbst_sync #(.W(3)) u_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async ({i_tck, i_pins.mode_sel, i_pins.ser_in}),
    .o_sync  (s_sync),
    .o_prev  (s_prev)
  );

  // pads are asynchronous to i_clk as well
  sbst_sync #(.W(sbst_pkg::BSC_MAX)) u_pad_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async (i_pad),
    .o_sync  (pad_sync),
    .o_prev  ()
  );

  assign tck_rise = s_sync[2] & ~s_prev[2];
  assign tck_fall = ~s_sync[2] & s_prev[2];

  sbst_pkg::sbst_state_t st_reg;
  sbst_pkg::sbst_state_t st_next;
  logic [2:0]            ir_reg;
  logic [2:0]            ir_next;
  logic [2:0]            irsh_reg;
  logic [2:0]            irsh_next;
  logic                  byp_reg;
  logic                  byp_next;
  logic [31:0]           id_reg;
  logic [31:0]           id_next;
  logic [NCELL-1:0]      bsc_reg;
  logic [NCELL-1:0]      bsc_next;
  logic                  tdo_reg;
  logic                  tdo_next;
  logic                  oe_reg;
  logic                  oe_next;
  logic                  flt_reg;
  logic                  flt_next;
  logic                  ser_bit;
  logic                  tms;
  logic                  tdi;
  logic [31:0]           id_word;
  logic [NCELL-1:0]      pad_obs;
  logic                  is_bsc;
  logic                  is_id;
  logic                  is_byp;

  assign tms = s_sync[1];
  assign tdi = s_sync[0];

  assign id_word = {sbst_pkg::ID_REV,
                    WIDE ? sbst_pkg::ID_CFG_WIDE : sbst_pkg::ID_CFG_NARR,
                    sbst_pkg::ID_VND, sbst_pkg::ID_MFR, 1'b1};

  // cells only observe pads; unconnected places forced low
  genvar g;
  generate
    for (g = 0; g < NCELL; g++) begin : g_cell
      if ((WIDE && (g == sbst_pkg::NC_WIDE_A - 1 ||
                    g == sbst_pkg::NC_WIDE_B - 1)) ||
          (!WIDE && (g == sbst_pkg::NC_NARR_A - 1 ||
                     g == sbst_pkg::NC_NARR_B - 1))) begin : g_nc
        assign pad_obs[g] = 1'b0;
      end else begin : g_pad
        assign pad_obs[g] = pad_sync[g];
      end
    end
  endgenerate

  // decode
  assign is_bsc = (ir_reg == sbst_pkg::IR_FLOAT_A) ||
                  (ir_reg == sbst_pkg::IR_FLOAT_B) ||
                  (ir_reg == sbst_pkg::IR_SAMPLE);
  assign is_id  = (ir_reg == sbst_pkg::IR_IDENT);
  assign is_byp = !is_bsc && !is_id;

  // standard diagram, advanced only on a rising test clock
  always_comb begin
    st_next = st_reg;
    if (tck_rise) begin
      case (st_reg)
        sbst_pkg::ST_RESET:    st_next = tms ? sbst_pkg::ST_RESET
                                             : sbst_pkg::ST_IDLE;
        sbst_pkg::ST_IDLE:     st_next = tms ? sbst_pkg::ST_SEL_DR
                                             : sbst_pkg::ST_IDLE;
        sbst_pkg::ST_SEL_DR:   st_next = tms ? sbst_pkg::ST_SEL_IR
                                             : sbst_pkg::ST_CAP_DR;
        sbst_pkg::ST_CAP_DR:   st_next = tms ? sbst_pkg::ST_EX1_DR
                                             : sbst_pkg::ST_SH_DR;
        sbst_pkg::ST_SH_DR:    st_next = tms ? sbst_pkg::ST_EX1_DR
                                             : sbst_pkg::ST_SH_DR;
        sbst_pkg::ST_EX1_DR:   st_next = tms ? sbst_pkg::ST_UPD_DR
                                             : sbst_pkg::ST_PAUSE_DR;
        sbst_pkg::ST_PAUSE_DR: st_next = tms ? sbst_pkg::ST_EX2_DR
                                             : sbst_pkg::ST_PAUSE_DR;
        sbst_pkg::ST_EX2_DR:   st_next = tms ? sbst_pkg::ST_UPD_DR
                                             : sbst_pkg::ST_SH_DR;
        sbst_pkg::ST_UPD_DR:   st_next = tms ? sbst_pkg::ST_SEL_DR
                                             : sbst_pkg::ST_IDLE;
        sbst_pkg::ST_SEL_IR:   st_next = tms ? sbst_pkg::ST_RESET
                                             : sbst_pkg::ST_CAP_IR;
        sbst_pkg::ST_CAP_IR:   st_next = tms ? sbst_pkg::ST_EX1_IR
                                             : sbst_pkg::ST_SH_IR;
        sbst_pkg::ST_SH_IR:    st_next = tms ? sbst_pkg::ST_EX1_IR
                                             : sbst_pkg::ST_SH_IR;
        sbst_pkg::ST_EX1_IR:   st_next = tms ? sbst_pkg::ST_UPD_IR
                                             : sbst_pkg::ST_PAUSE_IR;
        sbst_pkg::ST_PAUSE_IR: st_next = tms ? sbst_pkg::ST_EX2_IR
                                             : sbst_pkg::ST_PAUSE_IR;
        sbst_pkg::ST_EX2_IR:   st_next = tms ? sbst_pkg::ST_UPD_IR
                                             : sbst_pkg::ST_SH_IR;
        sbst_pkg::ST_UPD_IR:   st_next = tms ? sbst_pkg::ST_SEL_DR
                                             : sbst_pkg::ST_IDLE;
        default:               st_next = sbst_pkg::ST_RESET;
      endcase
    end
  end

  // registers shift or capture on the rising edge of the test clock
  always_comb begin
    ir_next   = ir_reg;
    irsh_next = irsh_reg;
    byp_next  = byp_reg;
    id_next   = id_reg;
    bsc_next  = bsc_reg;
    if (st_reg == sbst_pkg::ST_RESET) begin
      ir_next = sbst_pkg::IR_IDENT;
    end
    if (tck_rise) begin
      case (st_reg)
        sbst_pkg::ST_CAP_IR: irsh_next = sbst_pkg::IR_CAP;
        sbst_pkg::ST_SH_IR:  irsh_next = {tdi, irsh_reg[2:1]};
        sbst_pkg::ST_CAP_DR: begin
          id_next  = id_word;
          bsc_next = pad_obs;
        end
        sbst_pkg::ST_SH_DR: begin
          if (is_id) begin
            id_next = {tdi, id_reg[31:1]};
          end
          if (is_bsc) begin
            bsc_next = {tdi, bsc_reg[NCELL-1:1]};
          end
          if (is_byp) begin
            byp_next = tdi; // held after exit
          end
        end
        default: begin
        end
      endcase
    end
    // update taken at the rising edge leaving the update state
    if (tck_rise && st_reg == sbst_pkg::ST_UPD_IR) begin
      ir_next = irsh_reg;
      byp_next = 1'b0;
    end
  end

  // serial output launched on the falling test clock
  always_comb begin
    ser_bit = byp_reg;
    if (st_reg == sbst_pkg::ST_SH_IR) begin
      ser_bit = irsh_reg[0];
    end else if (is_id) begin
      ser_bit = id_reg[0];
    end else if (is_bsc) begin
      ser_bit = bsc_reg[0];
    end
    tdo_next = tdo_reg;
    oe_next  = oe_reg;
    if (tck_fall) begin
      tdo_next = ser_bit;
      oe_next  = (st_reg == sbst_pkg::ST_SH_DR) ||
                 (st_reg == sbst_pkg::ST_SH_IR);
    end
    // float only for the two float codes, plain sample drives
    flt_next = (ir_reg == sbst_pkg::IR_FLOAT_A) ||
               (ir_reg == sbst_pkg::IR_FLOAT_B);
  end

  // power-up reset stands for the missing test reset
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg   <= sbst_pkg::ST_RESET;
      ir_reg   <= sbst_pkg::IR_IDENT;
      irsh_reg <= '0;
      byp_reg  <= 1'b0;
      id_reg   <= '0;
      bsc_reg  <= '0;
      tdo_reg  <= 1'b0;
      oe_reg   <= 1'b0;
      flt_reg  <= 1'b0;
    end else begin
      st_reg   <= st_next;
      ir_reg   <= ir_next;
      irsh_reg <= irsh_next;
      byp_reg  <= byp_next;
      id_reg   <= id_next;
      bsc_reg  <= bsc_next;
      tdo_reg  <= tdo_next;
      oe_reg   <= oe_next;
      flt_reg  <= flt_next;
    end
  end

  assign o_tdo        = tdo_reg;
  assign o_tdo_oe     = oe_reg;
  assign o_data_float = flt_reg;

  default clocking cb_sys @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  a_reset_loads_id: assert property (st_reg == sbst_pkg::ST_RESET
    |=> ir_reg == sbst_pkg::IR_IDENT)
    else $error("reset state did not load id instruction");
  a_five_ones_reset: assert property (tck_rise && tms
    && st_reg == sbst_pkg::ST_SEL_IR |=> st_reg == sbst_pkg::ST_RESET)
    else $error("controller missed test-logic-reset");
  a_float_codes: assert property (##1 flt_reg ==
    ($past(ir_reg) == 3'h0 || $past(ir_reg) == 3'h2))
    else $error("float output wrong for instruction");
  a_sample_drives: assert property (ir_reg == sbst_pkg::IR_SAMPLE
    |=> !flt_reg)
    else $error("sample code floated the data pins");
  a_bypass_clear: assert property (tck_rise
    && st_reg == sbst_pkg::ST_UPD_IR |=> !byp_reg)
    else $error("bypass not cleared on update");
  a_bypass_hold: assert property (!tck_rise
    && st_reg != sbst_pkg::ST_UPD_IR |=> $stable(byp_reg))
    else $error("bypass changed without a shift");
  a_id_shift: assert property (tck_rise && is_id
    && st_reg == sbst_pkg::ST_SH_DR |=> id_reg[31] == $past(tdi))
    else $error("serial in not shifted into id");
  a_id_start: assert property (tck_rise
    && st_reg == sbst_pkg::ST_CAP_DR |=> id_reg[0])
    else $error("id start bit not one");
  a_tdo_falling: assert property (!tck_fall |=> $stable(tdo_reg))
    else $error("serial out moved off a falling edge");
  a_state_hold: assert property (!tck_rise |=> $stable(st_reg))
    else $error("state moved without rising test clock");
endmodule // sbst_tap
`default_nettype wire

// >>> tb/sbst_scan_ctl.sv
/*
  sbst_scan_ctl: behavioural scan controller on the far side of the port.
  assumes: the bench calls step and release_pins in sequence; pull-ups on
  mode select and serial in, test clock parked low outside frames.
*/
`timescale 1ns/10ps
`default_nettype none
module sbst_scan_ctl (
  input  wire logic            i_clk,
  input  wire logic            i_tdo,
  output logic                 o_tck,
  output sbst_pkg::sbst_pins_t o_pins
);
  int gap;

  initial begin
    gap    = 0;
    o_tck  = 1'b0;
    o_pins = '{mode_sel: 1'b1, ser_in: 1'b1};
  end

  // one test clock period; extra low cycles make a slow controller
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge i_clk);
    #1;
    o_pins.mode_sel = tms;
    o_pins.ser_in   = tdi;
    repeat (3 + gap) @(posedge i_clk);
    #1;
    o_tck = 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    // late sample: the port answers a few cycles after the fall
    tdo   = i_tdo;
    o_tck = 1'b0;
  endtask

  // lines let go return to the pull-up level
  task automatic release_pins();
    @(posedge i_clk);
    #1;
    o_pins.mode_sel = 1'b1;
    o_pins.ser_in   = 1'b1;
  endtask
endmodule // sbst_scan_ctl
`default_nettype wire

// >>> tb/tb_sbst_tap.sv
/*
  tb_sbst_tap: self-checking bench for the boundary-scan test port.
  assumes: wide organisation, scan controller model drives the test pins.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_sbst_tap;
  logic                 i_clk;
  logic                 i_srst;
  logic                 tck;
  sbst_pkg::sbst_pins_t pins;
  logic [69:0]          pad;
  logic                 tdo;
  logic                 tdo_oe;
  logic                 data_float;
  int                   mismatches;
  int                   comparisons;
  logic [31:0]          seed;
  logic [127:0]         din;
  logic [127:0]         dout;
  logic                 oe;
  logic                 t;
  int                   n;

  always #25 i_clk = ~i_clk;

  sbst_tap #(.WIDE(1'b1)) i_sbst_tap (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_tck       (tck),
    .i_pins      (pins),
    .i_pad       (pad),
    .o_tdo       (tdo),
    .o_tdo_oe    (tdo_oe),
    .o_data_float(data_float)
  );

  sbst_scan_ctl i_sbst_scan_ctl (
    .i_clk (i_clk),
    .i_tdo (tdo),
    .o_tck (tck),
    .o_pins(pins)
  );

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [127:0] rbits();
    logic [127:0] v;
    logic [31:0]  s;
    for (int i = 0; i < 128; i++) begin
      s    = rnd();
      v[i] = s[0];
    end
    return v;
  endfunction

  function automatic logic [31:0] id_word();
    return {sbst_pkg::ID_REV, sbst_pkg::ID_CFG_WIDE, sbst_pkg::ID_VND,
            sbst_pkg::ID_MFR, 1'b1};
  endfunction

  function automatic logic [69:0] chain_exp(input logic [69:0] p);
    logic [69:0] v;
    v                          = p;
    v[sbst_pkg::NC_WIDE_A - 1] = 1'b0;
    v[sbst_pkg::NC_WIDE_B - 1] = 1'b0;
    return v;
  endfunction

  task automatic check(input string what, input logic [127:0] seen,
                       input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // from reset or idle: scan n bits, pause once at brk, end in idle
  task automatic scan(input bit ir, input int n, input int brk,
                      input logic [127:0] d, output logic [127:0] q,
                      output logic shift_oe);
    logic b;
    q        = '0;
    shift_oe = 1'b0;
    i_sbst_scan_ctl.step(1'b0, 1'b1, b);
    i_sbst_scan_ctl.step(1'b1, 1'b1, b);
    if (ir) begin
      i_sbst_scan_ctl.step(1'b1, 1'b1, b);
    end
    i_sbst_scan_ctl.step(1'b0, 1'b1, b);
    i_sbst_scan_ctl.step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      i_sbst_scan_ctl.step(logic'(i == n - 1 || i == brk), d[i], b);
      q[i] = b;
      if (i == 0) begin
        shift_oe = tdo_oe;
      end
      if (i == brk && i != n - 1) begin
        i_sbst_scan_ctl.step(1'b0, 1'b1, b);
        i_sbst_scan_ctl.step(1'b1, 1'b1, b);
        i_sbst_scan_ctl.step(1'b0, 1'b1, b);
      end
    end
    i_sbst_scan_ctl.step(1'b1, 1'b1, b);
    i_sbst_scan_ctl.step(1'b0, 1'b1, b);
    i_sbst_scan_ctl.release_pins();
  endtask

  // id path straight after a reset of either kind
  task automatic id_read();
    din = rbits();
    scan(1'b0, 64, 1 + int'(rnd() % 62), din, dout, oe);
    check("id_path", dout[63:0], {din[31:0], id_word()});
    check("shift_oe", oe, 1'b1);
    check("idle_oe", tdo_oe, 1'b0);
  endtask

  initial begin
    repeat (60000) @(posedge i_clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    i_clk       = 1'b0;
    i_srst      = 1'b1;
    pad         = '0;
    mismatches  = 0;
    comparisons = 0;
    seed        = 32'h964D;
    repeat (3) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    check("reset_oe", tdo_oe, 1'b0);
    check("reset_float", data_float, 1'b0);
    id_read();
    for (int code = 0; code < 8; code++) begin
      i_sbst_scan_ctl.gap = int'(rnd() % 3);
      din = rbits();
      pad = din[69:0];
      scan(1'b1, 3, 1, 128'(code), dout, oe);
      check("ir_capture", dout[2:0], sbst_pkg::IR_CAP);
      check("data_float", data_float, code == 0 || code == 2);
      din = rbits();
      n   = (code == 1) ? 32 : (code == 3 || code > 4) ? 8 : 70;
      scan(1'b0, n, 1 + int'(rnd() % (n - 2)), din, dout, oe);
      if (n == 32) begin
        check("id_again", dout[31:0], id_word());
      end else if (n == 8) begin
        check("bypass", dout[7:0], {din[6:0], 1'b0});
      end else begin
        check("chain", dout[69:0], chain_exp(pad));
      end
    end
    i_sbst_scan_ctl.gap = 0;
    // float code first, so the reset below has something to undo
    scan(1'b1, 3, 1, 128'(sbst_pkg::IR_FLOAT_B), dout, oe);
    check("float_set", data_float, 1'b1);
    // five undriven-level highs bring the controller home
    repeat (5) i_sbst_scan_ctl.step(1'b1, 1'b1, t);
    i_sbst_scan_ctl.release_pins();
    check("float_after_reset", data_float, 1'b0);
    id_read();
    wrap_up();
  end
endmodule // tb_sbst_tap
`default_nettype wire
